/* File: core/scpm_consts.svh */
// Register layout, reset values and timing counts for the clock and power-mode controller
`ifndef SCPM_CONSTS_SVH
`define SCPM_CONSTS_SVH
`define SCPM_ADDR_MODE_CTRL 4'h0
`define SCPM_ADDR_PWR_CTRL 4'h1
`define SCPM_ADDR_STATUS 4'h2
`define SCPM_ADDR_CLK_STATE 4'h3
`define SCPM_BIT_HLSEL 0
`define SCPM_BIT_IDLE_EN 1
`define SCPM_BIT_HRDY 2
`define SCPM_BIT_LRDY 3
`define SCPM_BIT_FAST 4
`define SCPM_DIV_LSB 5
`define SCPM_MODE_RESET 8'h03
`define SCPM_PWR_RESET 8'h00
`define SCPM_XTAL_SETTLE 11'h400
`define SCPM_RC_SETTLE 11'h00f
`define SCPM_RUN_SETTLE 11'h001
`define SCPM_LOW_SETTLE 11'h001
`endif

/* File: core/scpm_pkg.sv */
// Types shared by the clock and power-mode controller
package scpm_pkg;
    typedef enum logic [1:0] {
        SCPM_OSC_XTAL,
        SCPM_OSC_ERC,
        SCPM_OSC_INTERNAL_FAST_RC_OSCILLATOR,
        SCPM_OSC_INTERNAL_SLOW_RC_OSCILLATOR
    } scpm_osc_t;
    typedef enum logic [2:0] {
        SCPM_RUN,
        SCPM_SLEEP_DEEP,
        SCPM_SLEEP_SUB,
        SCPM_IDLE_STOP,
        SCPM_IDLE_RUN,
        SCPM_WAKE
    } scpm_pmode_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scpm_bus_req_t;
    // Clock selection result: 0 low-speed, 1..6 divide 64..2, 7 undivided
    typedef struct packed {
        logic cpu_run;
        logic sys_clk_on;
        logic on_substitute;
        logic high_osc_on;
        logic low_osc_on;
        logic div_clks_on;
        logic wdt_clk_on;
        logic [2:0] clk_sel;
    } scpm_clk_ctl_t;
endpackage : scpm_pkg

/* File: core/scpm_settle.sv */
`timescale 1ns/1ps
// Oscillator settle counter: counts oscillator ticks until ready
`include "scpm_consts.svh"
module scpm_settle #(
    parameter int W = 11
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic tick_i,
    input wire logic [W-1:0] target_i,
    output logic ready_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
        logic ready;
    } scpm_settle_st_t;
    scpm_settle_st_t st;
    scpm_settle_st_t next_st;
    always_comb begin
        next_st = st;
        if (stop_i) begin
            next_st.busy = 1'b0;
            next_st.ready = 1'b0;
            next_st.cnt = '0;
        end else if (start_i) begin
            next_st.busy = 1'b1;
            next_st.ready = 1'b0;
            next_st.cnt = '0;
        end else if (st.busy && tick_i) begin
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt + 1'b1 >= target_i) begin
                next_st.busy = 1'b0;
                next_st.ready = 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end
    assign ready_o = st.ready;
endmodule : scpm_settle

/* File: core/scpm_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - Halt with idle enable and keep-on set enters clock-running idle.
// - Clock-running idle keeps system oscillator and watchdog clock running.
// - Divider 000/001 low-speed; 010..110 select high clock divided 64..4.
// - High/low select 1 routes undivided high clock, 0 routes divider choice.
// - Moving system clock to low-speed stops the high-speed oscillator.
// - Divided internal clocks stop while the high oscillator is stopped.
// - Fast wake-up bit lets substitute clock run system; crystal only.
// - Low-ready reads 0 in deepest sleep, rises 1-2 low ticks after wake.
// - High-ready clears when stopped; sets after 1024 crystal or 15-16 RC ticks, or 1-2 ticks in clock-running idle.
// - Halt: idle enable picks idle, keep-on picks running/stopped; else sleep.
// - Fast wake-up only from substitute sleep or clock-stopped idle.
// - Crystal fast wake runs on substitute, switches after 1024 crystal ticks.
// - RC oscillators wake in 15-16 or 1-2 ticks; fast bit ignored.
// - Watchdog off means no fast wake-up from deepest sleep.
// - Sleep halt goes deepest if watchdog and detector off, else substitute.
// - A halt in run mode sets power-down flag and clears watchdog timeout flag, unless a timeout lands in the same cycle.
`include "scpm_consts.svh"
module scpm_ctrl #(
    parameter scpm_pkg::scpm_osc_t OSC_TYPE = scpm_pkg::SCPM_OSC_XTAL
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic halt_i,
    input wire logic wake_i,
    input wire logic wdt_timeout_i,
    input wire logic clr_wdt_i,
    input wire logic high_osc_tick_i,
    input wire logic low_osc_tick_i,
    output logic cpu_run_o,
    output logic sys_clk_on_o,
    output logic on_substitute_o,
    output logic high_osc_on_o,
    output logic low_osc_on_o,
    output logic div_clks_on_o,
    output logic wdt_clk_on_o,
    output logic [2:0] clk_sel_o,
    output logic power_down_flag_o,
    output logic watchdog_timeout_flag_o
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0] clock_divider_select;
        logic fast_wakeup_enable;
        logic idle_on_halt_enable;
        logic high_low_clock_select;
        logic system_clock_keep_on;
        logic wdt_enable;
        logic wdt_clk_from_sub;
        logic lvd_enable;
        logic power_down_flag;
        logic watchdog_timeout_flag;
        scpm_pkg::scpm_pmode_t pmode;
        logic fast_wake;
        logic [1:0] tick_sync;
        logic tick_q;
        logic [1:0] low_sync;
        logic low_q;
        logic [7:0] rdata;
    } scpm_st_t;
    scpm_st_t st;
    scpm_st_t next_st;
    logic high_tick;
    logic low_tick;
    logic hi_start;
    logic hi_stop;
    logic lo_start;
    logic lo_stop;
    logic high_ready;
    logic low_ready;
    logic hi_needed;
    logic hi_busy_q;
    logic lo_busy_q;
    logic [10:0] hi_target;
    logic [7:0] mode_rd;
    scpm_pkg::scpm_clk_ctl_t ctl;
    ////////////////////////////////////////////////////////////////////////////
    // Oscillator ticks come from other clocks: edge-detect after two flops
    assign high_tick = st.tick_sync[1] ^ st.tick_q;
    assign low_tick = st.low_sync[1] ^ st.low_q;
    assign hi_target = (OSC_TYPE == scpm_pkg::SCPM_OSC_XTAL) ? `SCPM_XTAL_SETTLE
                     : `SCPM_RC_SETTLE;
    assign mode_rd = {st.clock_divider_select, st.fast_wakeup_enable, low_ready,
                      high_ready, st.idle_on_halt_enable, st.high_low_clock_select};
    // High oscillator is needed whenever the selected system clock is not low-speed
    assign hi_needed = st.high_low_clock_select || (st.clock_divider_select[2:1] != 2'b00);
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.tick_sync = {st.tick_sync[0], high_osc_tick_i};
        next_st.tick_q = st.tick_sync[1];
        next_st.low_sync = {st.low_sync[0], low_osc_tick_i};
        next_st.low_q = st.low_sync[1];
        next_st.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i[3:0])
                `SCPM_ADDR_MODE_CTRL: next_st.rdata = mode_rd;
                `SCPM_ADDR_PWR_CTRL: next_st.rdata = {4'h0, st.lvd_enable,
                    st.wdt_clk_from_sub, st.wdt_enable, st.system_clock_keep_on};
                `SCPM_ADDR_STATUS: next_st.rdata = {6'h00, st.watchdog_timeout_flag,
                    st.power_down_flag};
                `SCPM_ADDR_CLK_STATE: next_st.rdata = {st.fast_wake, st.pmode, 1'b0,
                    ctl.clk_sel};
                default: next_st.rdata = 8'h00;
            endcase
        end
        if (wr_i && addr_i[3:0] == `SCPM_ADDR_MODE_CTRL) begin
            next_st.clock_divider_select = wdata_i[7:5];
            next_st.fast_wakeup_enable = wdata_i[`SCPM_BIT_FAST];
            next_st.idle_on_halt_enable = wdata_i[`SCPM_BIT_IDLE_EN];
            next_st.high_low_clock_select = wdata_i[`SCPM_BIT_HLSEL];
        end
        if (wr_i && addr_i[3:0] == `SCPM_ADDR_PWR_CTRL) begin
            next_st.system_clock_keep_on = wdata_i[0];
            next_st.wdt_enable = wdata_i[1];
            next_st.wdt_clk_from_sub = wdata_i[2];
            next_st.lvd_enable = wdata_i[3];
        end
        if (clr_wdt_i) begin
            next_st.power_down_flag = 1'b0;
            next_st.watchdog_timeout_flag = 1'b0;
        end
        case (st.pmode)
            scpm_pkg::SCPM_RUN: begin
                if (halt_i) begin
                    next_st.power_down_flag = 1'b1;
                    next_st.watchdog_timeout_flag = 1'b0;
                    if (st.idle_on_halt_enable) begin
                        next_st.pmode = st.system_clock_keep_on ? scpm_pkg::SCPM_IDLE_RUN
                                      : scpm_pkg::SCPM_IDLE_STOP;
                    end else if (st.wdt_enable || st.lvd_enable) begin
                        next_st.pmode = scpm_pkg::SCPM_SLEEP_SUB;
                    end else begin
                        next_st.pmode = scpm_pkg::SCPM_SLEEP_DEEP;
                    end
                end
            end
            scpm_pkg::SCPM_IDLE_RUN: begin
                if (wake_i) begin
                    next_st.pmode = scpm_pkg::SCPM_WAKE;
                    next_st.fast_wake = 1'b0;
                end
            end
            scpm_pkg::SCPM_SLEEP_DEEP,
            scpm_pkg::SCPM_SLEEP_SUB,
            scpm_pkg::SCPM_IDLE_STOP: begin
                if (wake_i) begin
                    next_st.pmode = scpm_pkg::SCPM_WAKE;
                    // Substitute clock is dead in deepest sleep, so no fast start there
                    next_st.fast_wake = st.fast_wakeup_enable && hi_needed
                        && (OSC_TYPE == scpm_pkg::SCPM_OSC_XTAL)
                        && (st.pmode != scpm_pkg::SCPM_SLEEP_DEEP);
                end
            end
            scpm_pkg::SCPM_WAKE: begin
                // RC types ignore the fast bit: CPU waits for the oscillator itself
                if (hi_needed ? high_ready : low_ready) begin
                    next_st.pmode = scpm_pkg::SCPM_RUN;
                    next_st.fast_wake = 1'b0;
                end
            end
            default: next_st.pmode = scpm_pkg::SCPM_RUN;
        endcase
        // Timeout event comes last so it wins over a clear or a halt in the same cycle
        if (wdt_timeout_i) begin
            next_st.watchdog_timeout_flag = 1'b1;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.idle_on_halt_enable <= 1'b1;
            st.high_low_clock_select <= 1'b1;
            st.pmode <= scpm_pkg::SCPM_WAKE;
        end else if (ce_i) begin
            st <= next_st;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Clock routing and gating
    always_comb begin
        ctl = '0;
        if (st.high_low_clock_select) begin
            ctl.clk_sel = 3'h7;
        end else begin
            case (st.clock_divider_select)
                3'h0, 3'h1: ctl.clk_sel = 3'h0;
                3'h7: ctl.clk_sel = 3'h6;
                default: ctl.clk_sel = st.clock_divider_select - 3'h1;
            endcase
        end
        ctl.cpu_run = (st.pmode == scpm_pkg::SCPM_RUN)
                   || (st.pmode == scpm_pkg::SCPM_WAKE && st.fast_wake);
        ctl.on_substitute = st.pmode == scpm_pkg::SCPM_WAKE && st.fast_wake;
        ctl.sys_clk_on = ctl.cpu_run || st.pmode == scpm_pkg::SCPM_IDLE_RUN;
        // High oscillator stops when unused, in either sleep mode or in clock-stopped idle
        ctl.high_osc_on = hi_needed && (st.pmode == scpm_pkg::SCPM_RUN
                       || st.pmode == scpm_pkg::SCPM_WAKE
                       || st.pmode == scpm_pkg::SCPM_IDLE_RUN);
        ctl.div_clks_on = ctl.high_osc_on;
        ctl.low_osc_on = st.pmode != scpm_pkg::SCPM_SLEEP_DEEP;
        ctl.wdt_clk_on = st.pmode == scpm_pkg::SCPM_IDLE_RUN
                      || (st.pmode != scpm_pkg::SCPM_SLEEP_DEEP
                          && (st.wdt_clk_from_sub || ctl.sys_clk_on));
    end
    assign hi_stop = !ctl.high_osc_on;
    assign hi_start = ctl.high_osc_on && !high_ready && !hi_busy_q;
    assign lo_stop = !ctl.low_osc_on;
    assign lo_start = ctl.low_osc_on && !low_ready && !lo_busy_q;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hi_busy_q <= 1'b0;
            lo_busy_q <= 1'b0;
        end else if (ce_i) begin
            hi_busy_q <= ctl.high_osc_on && !high_ready;
            lo_busy_q <= ctl.low_osc_on && !low_ready;
        end
    end
    scpm_settle #(.W(11)) u_hi (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(hi_start),
        .stop_i(hi_stop),
        .tick_i(high_tick),
        .target_i(st.pmode == scpm_pkg::SCPM_IDLE_RUN ? `SCPM_RUN_SETTLE : hi_target),
        .ready_o(high_ready)
    );
    scpm_settle #(.W(11)) u_lo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(lo_start),
        .stop_i(lo_stop),
        .tick_i(low_tick),
        .target_i(`SCPM_LOW_SETTLE),
        .ready_o(low_ready)
    );
    ////////////////////////////////////////////////////////////////////////////
    assign rdata_o = st.rdata;
    assign cpu_run_o = ctl.cpu_run;
    assign sys_clk_on_o = ctl.sys_clk_on;
    assign on_substitute_o = ctl.on_substitute;
    assign high_osc_on_o = ctl.high_osc_on;
    assign low_osc_on_o = ctl.low_osc_on;
    assign div_clks_on_o = ctl.div_clks_on;
    assign wdt_clk_on_o = ctl.wdt_clk_on;
    assign clk_sel_o = ctl.clk_sel;
    assign power_down_flag_o = st.power_down_flag;
    assign watchdog_timeout_flag_o = st.watchdog_timeout_flag;
    ////////////////////////////////////////////////////////////////////////////
    chk_halt_idle_run: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && st.pmode == scpm_pkg::SCPM_RUN && halt_i && st.idle_on_halt_enable
        && st.system_clock_keep_on |=> st.pmode == scpm_pkg::SCPM_IDLE_RUN)
        else $error("halt did not enter running idle");
    chk_idle_clocks_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
        st.pmode == scpm_pkg::SCPM_IDLE_RUN |-> sys_clk_on_o && wdt_clk_on_o && !cpu_run_o)
        else $error("running idle lost a clock");
    chk_div_low_sel: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !st.high_low_clock_select && st.clock_divider_select[2:1] == 2'b00
        |-> clk_sel_o == 3'h0 && !high_osc_on_o && !div_clks_on_o)
        else $error("low-speed select left high clock on");
    chk_div_by_two: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !st.high_low_clock_select && st.clock_divider_select == 3'h7 |-> clk_sel_o == 3'h6)
        else $error("divide by two not selected");
    chk_full_rate: assert property (@(posedge core_clk_i) disable iff (rst_i)
        st.high_low_clock_select |-> clk_sel_o == 3'h7)
        else $error("undivided clock not selected");
    chk_low_ready_deep: assert property (@(posedge core_clk_i) disable iff (rst_i)
        st.pmode == scpm_pkg::SCPM_SLEEP_DEEP ##1 st.pmode == scpm_pkg::SCPM_SLEEP_DEEP
        |-> !low_ready)
        else $error("low ready high in deepest sleep");
    chk_high_ready_stop: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $past(st.pmode) == scpm_pkg::SCPM_IDLE_STOP && st.pmode == scpm_pkg::SCPM_IDLE_STOP
        |-> !high_ready)
        else $error("high ready set while stopped");
    chk_no_fast_deep: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && st.pmode == scpm_pkg::SCPM_SLEEP_DEEP && wake_i |=> !st.fast_wake)
        else $error("fast wake from deepest sleep");
    chk_halt_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && st.pmode == scpm_pkg::SCPM_RUN && halt_i && !wdt_timeout_i
        |=> power_down_flag_o && !watchdog_timeout_flag_o)
        else $error("halt flags wrong");
    chk_sleep_sub: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ce_i && st.pmode == scpm_pkg::SCPM_RUN && halt_i && !st.idle_on_halt_enable
        && st.wdt_enable |=> st.pmode == scpm_pkg::SCPM_SLEEP_SUB)
        else $error("sleep with watchdog not substitute");
endmodule : scpm_ctrl

/* File: tb/tb_scpm_ctrl.sv */
// Self-checking bench for the clock and power-mode controller
`timescale 1ns/1ps
module tb_scpm_ctrl;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic halt_i = 1'b0;
    logic wake_i = 1'b0;
    logic wdt_timeout_i = 1'b0;
    logic clr_wdt_i = 1'b0;
    logic high_osc_tick_i = 1'b0;
    logic low_osc_tick_i = 1'b0;
    logic [7:0] rdata_o;
    logic cpu_run_o, sys_clk_on_o, on_substitute_o, high_osc_on_o, low_osc_on_o;
    logic div_clks_on_o, wdt_clk_on_o, power_down_flag_o, watchdog_timeout_flag_o;
    logic [2:0] clk_sel_o;
    logic [7:0] d;
    logic [2:0] low_div = 3'h0;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    scpm_ctrl dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .halt_i(halt_i), .wake_i(wake_i), .wdt_timeout_i(wdt_timeout_i),
        .clr_wdt_i(clr_wdt_i), .high_osc_tick_i(high_osc_tick_i),
        .low_osc_tick_i(low_osc_tick_i), .cpu_run_o(cpu_run_o),
        .sys_clk_on_o(sys_clk_on_o), .on_substitute_o(on_substitute_o),
        .high_osc_on_o(high_osc_on_o), .low_osc_on_o(low_osc_on_o),
        .div_clks_on_o(div_clks_on_o), .wdt_clk_on_o(wdt_clk_on_o),
        .clk_sel_o(clk_sel_o), .power_down_flag_o(power_down_flag_o),
        .watchdog_timeout_flag_o(watchdog_timeout_flag_o)
    );
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    // High oscillator ticks every cycle, low one every eighth, so both are far apart
    always @(posedge core_clk_i) begin
        high_osc_tick_i <= ~high_osc_tick_i;
        low_div <= low_div + 3'h1;
        if (low_div == 3'h7) begin
            low_osc_tick_i <= ~low_osc_tick_i;
        end
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t timeout", $time);
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        checks_done = checks_done + 1;
        if (ok !== 1'b1) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask : rd
    task automatic wait_hrdy();
        int n;
        logic [7:0] v;
        n = 0;
        v = 8'h00;
        while (v[2] !== 1'b1 && n < 3000) begin
            rd(8'h00, v);
            n = n + 1;
        end
        check(v[2] === 1'b1, "high ready never set");
    endtask : wait_hrdy
    // Halt into one low-power mode, then wake and time the return to running
    task automatic halt_wake(input logic [7:0] pwr, input logic [7:0] mode,
                             input scpm_pkg::scpm_pmode_t pm, input logic sys,
                             input logic fast, input int lo, input int hi);
        int n;
        logic [7:0] v;
        logic sub_seen;
        wr(8'h01, pwr);
        wr(8'h00, mode);
        rd(8'h01, v);
        check(v === pwr, "power control readback");
        @(posedge core_clk_i);
        wdt_timeout_i <= 1'b1;
        @(posedge core_clk_i);
        wdt_timeout_i <= 1'b0;
        rd(8'h02, v);
        check(v[1] === 1'b1, "timeout flag not set");
        check(watchdog_timeout_flag_o === 1'b1, "timeout flag pin not set");
        @(posedge core_clk_i);
        halt_i <= 1'b1;
        @(posedge core_clk_i);
        halt_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        check(cpu_run_o === 1'b0, "cpu still runs");
        check(sys_clk_on_o === sys, "system clock state");
        rd(8'h03, v);
        check(v[6:4] === pm, "power mode");
        rd(8'h02, v);
        check(v === 8'h01, "status after halt");
        check(power_down_flag_o === 1'b1 && watchdog_timeout_flag_o === 1'b0,
              "flag pins after halt");
        rd(8'h00, v);
        if (pm == scpm_pkg::SCPM_SLEEP_DEEP) begin
            check(v[3:2] === 2'b00, "ready flags in deep sleep");
            check(low_osc_on_o === 1'b0, "low osc in deep sleep");
        end
        if (pm == scpm_pkg::SCPM_IDLE_STOP || pm == scpm_pkg::SCPM_SLEEP_SUB) begin
            check(v[2] === 1'b0, "high ready while stopped");
            check(low_osc_on_o === 1'b1, "substitute clock off");
        end
        if (pm == scpm_pkg::SCPM_IDLE_RUN) begin
            check(wdt_clk_on_o === 1'b1 && high_osc_on_o === 1'b1, "idle clocks");
        end
        @(posedge core_clk_i);
        wake_i <= 1'b1;
        @(posedge core_clk_i);
        wake_i <= 1'b0;
        // Let the edge that takes the wake settle before looking at the outputs
        #1;
        n = 1;
        sub_seen = (on_substitute_o === 1'b1);
        while (cpu_run_o !== 1'b1 && n < 5000) begin
            @(posedge core_clk_i);
            #1;
            n = n + 1;
            if (on_substitute_o === 1'b1) begin
                sub_seen = 1'b1;
            end
        end
        check(n >= lo && n <= hi, "wake latency");
        check(sub_seen === fast, "substitute clock use");
        while (on_substitute_o === 1'b1 && n < 5000) begin
            @(posedge core_clk_i);
            #1;
            n = n + 1;
        end
        // Ticks arrive one a cycle, so the crystal hand-over cannot come early
        check(!fast || n >= 1024, "early switch to crystal");
        check(cpu_run_o === 1'b1, "cpu stopped after wake");
        wait_hrdy();
        @(posedge core_clk_i);
        clr_wdt_i <= 1'b1;
        @(posedge core_clk_i);
        clr_wdt_i <= 1'b0;
        rd(8'h02, v);
        check(v === 8'h00, "flags after clear");
        check(power_down_flag_o === 1'b0, "power-down pin after clear");
    endtask : halt_wake
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        wait_hrdy();
        rd(8'h00, d);
        check(d === 8'h0f, "mode register after reset");
        check(clk_sel_o === 3'h7 && high_osc_on_o === 1'b1, "undivided select");
        // Clock enable low must swallow a write
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        wr(8'h00, 8'he0);
        ce_i <= 1'b1;
        rd(8'h00, d);
        check(d === 8'h0f, "write taken with clock enable low");
        wr(8'h02, 8'hff);
        rd(8'h02, d);
        check(d === 8'h00, "status not writable");
        wr(8'h03, 8'hff);
        rd(8'h05, d);
        check(d === 8'h00, "unmapped read");
        for (int i = 7; i >= 0; i--) begin
            wr(8'h00, {i[2:0], 5'h02});
            repeat (3) @(posedge core_clk_i);
            #1;
            check(clk_sel_o === ((i < 2) ? 3'h0 : 3'(i - 1)), "divider select");
            check(high_osc_on_o === (i >= 2), "high osc gating");
            check(div_clks_on_o === (i >= 2), "divided clocks gating");
        end
        wr(8'h00, 8'h03);
        wait_hrdy();
        halt_wake(8'h01, 8'h13, scpm_pkg::SCPM_IDLE_RUN, 1'b1, 1'b0, 1, 8);
        halt_wake(8'h00, 8'h13, scpm_pkg::SCPM_IDLE_STOP, 1'b0, 1'b1, 1, 40);
        halt_wake(8'h00, 8'h11, scpm_pkg::SCPM_SLEEP_DEEP, 1'b0, 1'b0, 1000, 1200);
        halt_wake(8'h02, 8'h11, scpm_pkg::SCPM_SLEEP_SUB, 1'b0, 1'b1, 1, 40);
        halt_wake(8'h08, 8'h01, scpm_pkg::SCPM_SLEEP_SUB, 1'b0, 1'b0, 1000, 1200);
        tally_and_finish();
    end
endmodule : tb_scpm_ctrl
